//--- include/sram_port_defines.svh
// Purpose: timing and geometry constants for the asynchronous SRAM host port
// Assumes: 125 MHz REF_CLK, 8 ns period
// Notes: times in ns; cycle counts derived, least times rounded up
`ifndef SRAM_PORT_DEFINES_SVH
`define SRAM_PORT_DEFINES_SVH
`define CLK_PERIOD_NS 8
`define ADDR_W 19
`define DATA_W 8
`define T_ADDR_TO_DATA_NS 20
`define T_ADDR_TO_DATA_HI_NS 25
`define T_READ_CYCLE_NS 20
`define T_SLEEP_ACCESS_NS 25
`define T_SELECT_RELEASE_NS 8
`define T_SLEEP_RELEASE_NS 10
`define T_WRITE_PULSE_NS 15
`define T_WRITE_PULSE_HI_NS 20
`define T_SELECT_TO_END_NS 16
`define T_DATA_SETUP_NS 12
`define T_ADDR_TO_END_NS 20
`define T_WRITE_RECOVERY_NS 5
`define T_WRITE_CYCLE_NS 20
`define T_WRITE_CYCLE_HI_NS 25
`define T_WE_RELEASE_NS 7
`define NS2CYC(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 4
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1
`endif

//--- include/sram_port_pkg.sv
// Purpose: types for the asynchronous SRAM host port
// Assumes: nothing
// Notes: state enumeration only
package sram_port_pkg;
   typedef enum logic [2:0] {ST_SLEEP, ST_IDLE, ST_READ, ST_WRITE, ST_RECOVER} port_state_e;
endpackage

//--- src/sram_bus_pins.sv
// Purpose: registered pin drivers for the SRAM data bus and controls
// Assumes: select, output enable and write strobe idle high after reset; awake low
// Notes: read data captured on request
`timescale 1ns/1ps
`include "sram_port_defines.svh"
module sram_bus_pins
#(
   parameter int AW = `ADDR_W,
   parameter int DW = `DATA_W
)
(
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic [AW-1:0] addr_d,
   input wire logic [DW-1:0] wdata_d,
   input wire logic sel_d,
   input wire logic oe_d,
   input wire logic we_d,
   input wire logic awake_d,
   input wire logic dq_oe_d,
   input wire logic capture,
   input wire logic [DW-1:0] dq_in,
   output logic [AW-1:0] addr_q,
   output logic [DW-1:0] dq_out_q,
   output logic dq_oe_q,
   output logic select_n_q,
   output logic drive_enable_n_q,
   output logic write_strobe_n_q,
   output logic awake_q,
   output logic [DW-1:0] rdata_q
);
   logic [DW-1:0] next_rdata;

   always_comb
   begin
      next_rdata = rdata_q;
      if (capture)
      begin
         next_rdata = dq_in;
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         addr_q <= '0;
         dq_out_q <= '0;
         dq_oe_q <= 1'b0;
         select_n_q <= 1'b1;
         drive_enable_n_q <= 1'b1;
         write_strobe_n_q <= 1'b1;
         awake_q <= 1'b0;
         rdata_q <= '0;
      end
      else
      begin
         addr_q <= addr_d;
         dq_out_q <= wdata_d;
         dq_oe_q <= dq_oe_d;
         select_n_q <= !sel_d;
         drive_enable_n_q <= !oe_d;
         write_strobe_n_q <= !we_d;
         awake_q <= awake_d;
         rdata_q <= next_rdata;
      end
   end
endmodule

//--- src/sram_delay_count.sv
// Purpose: loadable down counter for phase timing
// Assumes: load has priority over counting
// Notes: done is high while the count is zero
`timescale 1ns/1ps
`include "sram_port_defines.svh"
module sram_delay_count
#(
   parameter int W = `CNT_W
)
(
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic load,
   input wire logic [W-1:0] value,
   output logic done
);
   logic [W-1:0] count;
   logic [W-1:0] next_count;

   always_comb
   begin
      next_count = count;
      if (load)
      begin
         next_count = value;
      end
      else if (count != '0)
      begin
         next_count = count - W'(1);
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         count <= '0;
      end
      else
      begin
         count <= next_count;
      end
   end

   assign done = (count == '0);
endmodule

//--- src/sram_host_port.sv
// Purpose: host controller driving a 512K x 8 asynchronous static RAM
// Assumes: user request held until accepted; pins registered; inputs synchronous
// Notes: one access at a time; awake is lowered after an idle timeout
// Behaviour
// - Read: select, output enable low; awake, strobe high
// - Back-to-back reads keep select low, awake high
// - Address settles before select and awake change
// - Reads spaced no closer than read cycle
// - Write strobe low at least pulse width
// - Select low long before write end
// - Write data set up before strobe rises
// - Address valid before start, held through end; the code changes ADDR on the same edge that lowers the write strobe
// - Strobe high at least recovery between writes
// - Write cycles spaced at least cycle time
// - Write needs strobe, select low, awake high
// - Strobe returns high between consecutive writes
`timescale 1ns/1ps
`include "sram_port_defines.svh"
module sram_host_port
   import sram_port_pkg::*;
#(
   parameter int AW = `ADDR_W,
   parameter int DW = `DATA_W,
   parameter bit HIGH_DOSE = 1'b0,
   parameter int IDLE_SLEEP_CYCLES = 64
)
(
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic REQ_VALID,
   input wire logic REQ_WRITE,
   input wire logic [AW-1:0] REQ_ADDR,
   input wire logic [DW-1:0] REQ_WDATA,
   output logic REQ_READY,
   output logic RD_VALID,
   output logic [DW-1:0] RD_DATA,
   output logic [AW-1:0] ADDR,
   input wire logic [DW-1:0] DQ_IN,
   output logic [DW-1:0] DQ_OUT,
   output logic DQ_OE,
   output logic SELECT_N,
   output logic DRIVE_ENABLE_N,
   output logic WRITE_STROBE_N,
   output logic AWAKE
);
   // ==========================================================
   // Timing counts
   localparam int ACC_NS = HIGH_DOSE ? `T_ADDR_TO_DATA_HI_NS : `T_ADDR_TO_DATA_NS;
   // One extra cycle covers the pin register delay before sampling
   localparam logic [`CNT_W-1:0] C_READ = `CNT_W'(`NS2CYC(ACC_NS) + 1);
   localparam logic [`CNT_W-1:0] C_WAKE = `CNT_W'(`NS2CYC(`T_SLEEP_ACCESS_NS) + 1);
   localparam logic [`CNT_W-1:0] C_SEL_REL = `CNT_W'(`NS2CYC(`T_SELECT_RELEASE_NS));
   localparam logic [`CNT_W-1:0] C_SLP_REL = `CNT_W'(`NS2CYC(`T_SLEEP_RELEASE_NS));
   localparam int WP_NS = HIGH_DOSE ? `T_WRITE_PULSE_HI_NS : `T_WRITE_PULSE_NS;
   localparam int WPULSE = (`NS2CYC(WP_NS) > `NS2CYC(`T_SELECT_TO_END_NS)) ?
                           `NS2CYC(WP_NS) : `NS2CYC(`T_SELECT_TO_END_NS);
   localparam logic [`CNT_W-1:0] C_WPULSE = `CNT_W'(WPULSE);
   localparam logic [`CNT_W-1:0] C_WREC = `CNT_W'(`NS2CYC(`T_WRITE_RECOVERY_NS));
   localparam int CYC_NS = HIGH_DOSE ? `T_WRITE_CYCLE_HI_NS : `T_WRITE_CYCLE_NS;
   localparam int CYC_N = `NS2CYC(CYC_NS);

   // ==========================================================
   // State
   port_state_e state;
   port_state_e next_state;
   logic [AW-1:0] addr_r;
   logic [AW-1:0] next_addr_r;
   logic [DW-1:0] wdata_r;
   logic [DW-1:0] next_wdata_r;
   logic [15:0] idle_cnt;
   logic [15:0] next_idle_cnt;
   logic [3:0] since;
   logic [3:0] next_since;
   logic sel_d;
   logic oe_d;
   logic we_d;
   logic awake_d;
   logic dq_oe_d;
   logic capture;
   logic load;
   logic [`CNT_W-1:0] load_val;
   logic done;
   logic rd_valid;
   logic next_rd_valid;

   sram_delay_count #(.W(`CNT_W)) sram_delay_count_i
   (
      .REF_CLK(REF_CLK),
      .RST_B(RST_B),
      .load(load),
      .value(load_val),
      .done(done)
   );

   sram_bus_pins #(.AW(AW), .DW(DW)) sram_bus_pins_i
   (
      .REF_CLK(REF_CLK),
      .RST_B(RST_B),
      .addr_d(next_addr_r),
      .wdata_d(next_wdata_r),
      .sel_d(sel_d),
      .oe_d(oe_d),
      .we_d(we_d),
      .awake_d(awake_d),
      .dq_oe_d(dq_oe_d),
      .capture(capture),
      .dq_in(DQ_IN),
      .addr_q(ADDR),
      .dq_out_q(DQ_OUT),
      .dq_oe_q(DQ_OE),
      .select_n_q(SELECT_N),
      .drive_enable_n_q(DRIVE_ENABLE_N),
      .write_strobe_n_q(WRITE_STROBE_N),
      .awake_q(AWAKE),
      .rdata_q(RD_DATA)
   );

   // ==========================================================
   // Sequencer
   always_comb
   begin
      next_state = state;
      next_addr_r = addr_r;
      next_wdata_r = wdata_r;
      next_idle_cnt = idle_cnt;
      next_since = (since == 4'hF) ? since : since + 4'h1;
      next_rd_valid = 1'b0;
      load = 1'b0;
      load_val = `CNT_ZERO;
      capture = 1'b0;
      REQ_READY = 1'b0;
      sel_d = 1'b0;
      oe_d = 1'b0;
      we_d = 1'b0;
      awake_d = 1'b1;
      dq_oe_d = 1'b0;
      case (state)
         ST_SLEEP:
         begin
            awake_d = 1'b0;
            // Idle count restarts so the port does not drop back to sleep as soon as the wake wait ends
            next_idle_cnt = 16'h0;
            if (REQ_VALID && done)
            begin
               // Wake with address already set; select and awake follow one edge later: awake-started access
               next_addr_r = REQ_ADDR;
               next_state = ST_IDLE;
               load = 1'b1;
               load_val = C_WAKE;
            end
         end
         ST_IDLE:
         begin
            sel_d = 1'b1;
            next_idle_cnt = idle_cnt + 16'h1;
            if (REQ_VALID && done && since >= 4'(CYC_N))
            begin
               REQ_READY = 1'b1;
               next_idle_cnt = 16'h0;
               next_addr_r = REQ_ADDR;
               next_wdata_r = REQ_WDATA;
               next_since = 4'h0;
               load = 1'b1;
               if (REQ_WRITE)
               begin
                  we_d = 1'b1;
                  dq_oe_d = 1'b1;
                  load_val = C_WPULSE;
                  next_state = ST_WRITE;
               end
               else
               begin
                  oe_d = 1'b1;
                  load_val = C_READ;
                  next_state = ST_READ;
               end
            end
            else if (done && idle_cnt >= 16'(IDLE_SLEEP_CYCLES))
            begin
               awake_d = 1'b0;
               load = 1'b1;
               load_val = C_SLP_REL;
               next_state = ST_SLEEP;
            end
         end
         ST_READ:
         begin
            sel_d = 1'b1;
            oe_d = 1'b1;
            if (done)
            begin
               capture = 1'b1;
               next_rd_valid = 1'b1;
               oe_d = 1'b0;
               next_state = ST_IDLE;
               load = 1'b1;
               load_val = C_SEL_REL;
            end
         end
         ST_WRITE:
         begin
            sel_d = 1'b1;
            we_d = 1'b1;
            dq_oe_d = 1'b1;
            if (done)
            begin
               we_d = 1'b0;
               next_state = ST_RECOVER;
               load = 1'b1;
               load_val = C_WREC;
            end
         end
         ST_RECOVER:
         begin
            sel_d = 1'b1;
            dq_oe_d = 1'b1; // data held past strobe rise
            if (done)
            begin
               dq_oe_d = 1'b0;
               next_state = ST_IDLE;
            end
         end
         default:
         begin
            next_state = ST_SLEEP;
         end
      endcase
   end

   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         state <= ST_SLEEP;
         addr_r <= '0;
         wdata_r <= '0;
         idle_cnt <= 16'h0;
         since <= 4'hF;
         rd_valid <= 1'b0;
      end
      else
      begin
         state <= next_state;
         addr_r <= next_addr_r;
         wdata_r <= next_wdata_r;
         idle_cnt <= next_idle_cnt;
         since <= next_since;
         rd_valid <= next_rd_valid;
      end
   end

   assign RD_VALID = rd_valid;

   // ==========================================================
   // Checks
   property p_read_combo;
      @(posedge REF_CLK) disable iff (!RST_B)
      !DRIVE_ENABLE_N |-> !SELECT_N && AWAKE && WRITE_STROBE_N && !DQ_OE;
   endproperty
   a_read_combo: assert property (p_read_combo) else $error("bad read controls");

   property p_no_fight;
      @(posedge REF_CLK) disable iff (!RST_B)
      $fell(DRIVE_ENABLE_N) |-> !$past(DQ_OE);
   endproperty
   a_no_fight: assert property (p_no_fight) else $error("host drives into read");

   property p_write_combo;
      @(posedge REF_CLK) disable iff (!RST_B)
      !WRITE_STROBE_N |-> !SELECT_N && AWAKE && DQ_OE;
   endproperty
   a_write_combo: assert property (p_write_combo) else $error("bad write controls");

   property p_pulse;
      @(posedge REF_CLK) disable iff (!RST_B)
      $fell(WRITE_STROBE_N) |-> !WRITE_STROBE_N [*2];
   endproperty
   a_pulse: assert property (p_pulse) else $error("write pulse short");

   property p_recovery;
      @(posedge REF_CLK) disable iff (!RST_B)
      $rose(WRITE_STROBE_N) |=> WRITE_STROBE_N;
   endproperty
   a_recovery: assert property (p_recovery) else $error("recovery short");

   property p_addr_hold;
      @(posedge REF_CLK) disable iff (!RST_B)
      !WRITE_STROBE_N |=> $stable(ADDR);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved in write");

   property p_data_hold;
      @(posedge REF_CLK) disable iff (!RST_B)
      $rose(WRITE_STROBE_N) |-> DQ_OE && $stable(DQ_OUT);
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("data not held");

   property p_sleep_float;
      @(posedge REF_CLK) disable iff (!RST_B)
      !AWAKE |-> DRIVE_ENABLE_N && WRITE_STROBE_N && !DQ_OE;
   endproperty
   a_sleep_float: assert property (p_sleep_float) else $error("access while asleep");

   property p_read_wait;
      @(posedge REF_CLK) disable iff (!RST_B)
      $fell(DRIVE_ENABLE_N) |-> !DRIVE_ENABLE_N [*3];
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("read too short");
endmodule

//--- test/sram_device_model.sv
// Purpose: behavioural asynchronous 512K x 8 static RAM facing the host port
// Assumes: host pins change only on REF_CLK edges
// Notes: host timing faults are counted in errors; released bus toggles every ns
`timescale 1ns/1ps
`include "sram_port_defines.svh"
module sram_device_model
(
   input wire logic [`ADDR_W-1:0] addr,
   input wire logic [`DATA_W-1:0] wdata,
   input wire logic host_oe,
   input wire logic select_n,
   input wire logic drive_enable_n,
   input wire logic write_strobe_n,
   input wire logic awake,
   output logic [`DATA_W-1:0] dq,
   output logic dq_oe,
   output int errors
);
   // ==========================================
   // Array and edge times
   logic [`DATA_W-1:0] mem [logic [`ADDR_W-1:0]];
   realtime t_a = -99;
   realtime t_g = -99;
   realtime t_s = -99;
   realtime t_p = -99;
   realtime t_d = -99;
   realtime t_wl = -99;
   realtime t_wh = -99;
   logic drive;
   logic ready;

   // Unwritten words read back a pattern of their address
   function automatic logic [`DATA_W-1:0] fetch(input logic [`ADDR_W-1:0] a);
      return mem.exists(a) ? mem[a] : a[`DATA_W-1:0] ^ 8'hA5;
   endfunction

   initial
   begin
      dq = 8'h00;
      dq_oe = 1'b0;
      errors = 0;
   end

   always @(addr) t_a = $realtime;
   always @(negedge drive_enable_n) t_g = $realtime;
   always @(select_n) t_s = $realtime;
   always @(awake) t_p = $realtime;
   always @(wdata) t_d = $realtime;

   // ==========================================
   // Write timing
   always @(negedge write_strobe_n)
   begin
      if ($realtime - t_wh < `T_WRITE_RECOVERY_NS) errors++;
      if ($realtime - t_wl < `T_WRITE_CYCLE_NS) errors++;
      t_wl = $realtime;
   end

   always @(posedge write_strobe_n)
   begin
      if (!select_n && awake)
      begin
         if ($realtime - t_wl < `T_WRITE_PULSE_NS) errors++;
         if ($realtime - t_s < `T_SELECT_TO_END_NS) errors++;
         if ($realtime - t_d < `T_DATA_SETUP_NS) errors++;
         if ($realtime - t_a < `T_ADDR_TO_END_NS || t_a > t_wl) errors++;
         mem[addr] = wdata;
      end
      t_wh = $realtime;
   end

   // ==========================================
   // Read drivers
   always #1
   begin
      drive = awake && !select_n && !drive_enable_n && write_strobe_n
         && $realtime - t_s >= 4 && $realtime - t_p >= 5 && $realtime - t_wh >= 4;
      ready = $realtime - t_a >= `T_ADDR_TO_DATA_NS && $realtime - t_g >= 5
         && $realtime - t_s >= `T_ADDR_TO_DATA_NS && $realtime - t_p >= `T_SLEEP_ACCESS_NS;
      if (drive && host_oe) errors++;
      dq_oe = drive;
      dq = (drive && ready) ? fetch(addr) : ~dq;
   end
endmodule

//--- test/sram_host_port_bench.sv
// Purpose: self-checking bench for the asynchronous SRAM host port
// Assumes: behavioural device model on the pin side
// Notes: idle sleep count shortened to 8 cycles
`timescale 1ns/1ps
`include "sram_port_defines.svh"
`define CHECK(name, exp, got) \
   begin \
      checks++; \
      if ((got) !== (exp)) \
      begin \
         mismatches++; \
         $display("mismatch %s expected %0h seen %0h", name, exp, got); \
      end \
   end
module sram_host_port_bench;
   typedef struct packed {logic wr; logic [`ADDR_W-1:0] a; logic [`DATA_W-1:0] d;} row_s;
   logic REF_CLK = 1'b0;
   logic RST_B = 1'b0;
   logic REQ_VALID = 1'b0;
   logic REQ_WRITE = 1'b0;
   logic [`ADDR_W-1:0] REQ_ADDR = '0;
   logic [`DATA_W-1:0] REQ_WDATA = '0;
   logic REQ_READY, RD_VALID, DQ_OE, SELECT_N, DRIVE_ENABLE_N, WRITE_STROBE_N, AWAKE, dev_oe;
   logic [`DATA_W-1:0] RD_DATA, DQ_OUT, dev_dq;
   logic [`ADDR_W-1:0] ADDR;
   wire logic [`DATA_W-1:0] DQ_IN;
   int dev_errors;
   int mismatches = 0;
   int checks = 0;
   // ==========================================
   // Ordinary cases: writes, reads of the same places, a read of an unwritten place, then a write and read of it
   row_s rows [9] = '{'{1'b1, 19'h00000, 8'h3C}, '{1'b1, 19'h7FFFF, 8'hC3},
      '{1'b1, 19'h2AAAA, 8'h5A}, '{1'b0, 19'h00000, 8'h3C}, '{1'b0, 19'h7FFFF, 8'hC3},
      '{1'b0, 19'h2AAAA, 8'h5A}, '{1'b0, 19'h12345, 8'hE0}, '{1'b1, 19'h12345, 8'h81},
      '{1'b0, 19'h12345, 8'h81}};

   assign DQ_IN = DQ_OE ? DQ_OUT : dev_dq;
   always #4 REF_CLK = ~REF_CLK;

   sram_host_port #(.IDLE_SLEEP_CYCLES(8)) sram_host_port_i (.REF_CLK(REF_CLK), .RST_B(RST_B),
      .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR),
      .REQ_WDATA(REQ_WDATA), .REQ_READY(REQ_READY), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA),
      .ADDR(ADDR), .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .SELECT_N(SELECT_N),
      .DRIVE_ENABLE_N(DRIVE_ENABLE_N), .WRITE_STROBE_N(WRITE_STROBE_N), .AWAKE(AWAKE));

   sram_device_model sram_device_model_i (.addr(ADDR), .wdata(DQ_OUT), .host_oe(DQ_OE),
      .select_n(SELECT_N), .drive_enable_n(DRIVE_ENABLE_N), .write_strobe_n(WRITE_STROBE_N),
      .awake(AWAKE), .dq(dev_dq), .dq_oe(dev_oe), .errors(dev_errors));

   // ==========================================
   // Tasks
   task automatic stop_test;
      if (mismatches == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Holds the request until the edge that accepts it
   task automatic request(input row_s r);
      int n;
      REQ_VALID = 1'b1;
      REQ_WRITE = r.wr;
      REQ_ADDR = r.a;
      REQ_WDATA = r.d;
      n = 0;
      do
      begin
         @(posedge REF_CLK);
         n++;
      end
      while (REQ_READY !== 1'b1 && n < 50);
      if (n >= 50) mismatches++;
      #1;
      REQ_VALID = 1'b0;
   endtask

   task automatic access(input row_s r);
      int n;
      request(r);
      if (!r.wr)
      begin
         n = 0;
         while (RD_VALID !== 1'b1 && n < 20)
         begin
            @(posedge REF_CLK);
            #1;
            n++;
         end
         `CHECK("read latency", 5, n)
         `CHECK("read data", r.d, RD_DATA)
      end
      else
      begin
         // Lets an edge pass so the next request does not re-raise valid at once
         @(posedge REF_CLK);
         #1;
      end
   endtask

   task automatic pins_reset;
      `CHECK("reset pins", 5'h07, {AWAKE, DQ_OE, SELECT_N, DRIVE_ENABLE_N, WRITE_STROBE_N})
   endtask

   // ==========================================
   // Main sequence
   initial
   begin
      repeat (10) @(posedge REF_CLK);
      #1;
      pins_reset;
      RST_B = 1'b1;
      foreach (rows[i]) access(rows[i]);
      // Idle long enough for the port to put the part to sleep
      repeat (20) @(posedge REF_CLK);
      #1;
      `CHECK("sleep pins", 2'h0, {AWAKE, dev_oe})
      access(rows[4]);
      // Reset in the middle of a read, then read again
      request(rows[3]);
      @(posedge REF_CLK);
      #1;
      RST_B = 1'b0;
      #1;
      pins_reset;
      @(posedge REF_CLK);
      #1;
      RST_B = 1'b1;
      access(rows[5]);
      `CHECK("device faults", 0, dev_errors)
      stop_test;
   end

   initial
   begin
      #100000;
      mismatches++;
      stop_test;
   end
endmodule
